// ---- pkg/vos_pkg.sv ----
// Constants and types shared by the valve output supervision block
package vos_pkg;

    // Clock and persistence timing
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SAVE_PERIOD_S = 30;
    localparam logic [31:0] SAVE_CYCLES   =
        32'(64'(CLK_HZ) * 64'(SAVE_PERIOD_S));

    // Supply windows in millivolts
    localparam logic [15:0] CTRL_HI_MV = 16'h6590;
    localparam logic [15:0] CTRL_LO_MV = 16'h5208;
    localparam logic [15:0] OUT_HI_MV  = 16'h6590;
    localparam logic [15:0] OUT_LO_MV  = 16'h4e20;

    // Count limit range and scale
    localparam logic [15:0] LIMIT_MIN  = 16'h0001;
    localparam logic [15:0] LIMIT_MAX  = 16'hfde8;
    localparam logic [31:0] LIMIT_UNIT = 32'h0000_03e8;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_HT_CFG   = 8'h04;
    localparam logic [7:0] OFF_FAULT    = 8'h08;
    localparam logic [7:0] OFF_IDLE     = 8'h0c;
    localparam logic [7:0] OFF_LIMIT    = 8'h10;
    localparam logic [7:0] OFF_UNIT_ERR = 8'h14;
    localparam logic [7:0] OFF_CH_ERR   = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_CNT_SEL  = 8'h24;
    localparam logic [7:0] OFF_CNT_VAL  = 8'h28;

    // Control register fields
    localparam int CTRL_MON_BIT    = 0;
    localparam int OUT_MON_BIT     = 1;
    localparam int SHORT_EN_BIT    = 2;
    localparam int RESTART_MAN_BIT = 3;
    localparam int PRIO_HT_BIT     = 4;
    localparam int CTRL_W          = 5;
    localparam logic [4:0] CTRL_RST = 5'h07;

    // Terminal-only config fields
    localparam int OPEN_EN_BIT = 0;
    localparam int CNT_EN_BIT  = 1;
    localparam int LIMIT_EN_BIT = 16;
    localparam logic [15:0] LIMIT_RST = 16'hfde8;

    // Event bits: status, mask and unit error share this layout
    localparam int EV_CTRL_SUP = 0;
    localparam int EV_OUT_SUP  = 1;
    localparam int EV_SHORT    = 2;
    localparam int EV_OPEN     = 3;
    localparam int EV_COUNT    = 4;
    localparam int EV_W        = 5;

    typedef enum logic [1:0] {
        ACT_OFF      = 2'b00,
        ACT_HOLD     = 2'b01,
        ACT_FORCE_ON = 2'b10
    } vos_action_e;

    typedef enum logic [0:0] {
        SV_WAIT = 1'b0,
        SV_SEND = 1'b1
    } vos_save_e;

endpackage

// ---- hdl/vos_channel.sv ----
// One valve channel: output action, activation count and channel errors
`timescale 1ns/1ps
`default_nettype none
module vos_channel (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd,
    input  wire logic        comm_fault,
    input  wire logic        comm_idle,
    input  wire logic        prio_ht,
    input  wire logic        unit_hold,
    input  wire logic [1:0]  fault_act,
    input  wire logic [1:0]  idle_act,
    input  wire logic        open_sense,
    input  wire logic        open_en,
    input  wire logic        cnt_en,
    input  wire logic [15:0] limit,
    input  wire logic        load_valid,
    input  wire logic [31:0] load_count,
    output logic             valve_out,
    output logic [31:0]      count,
    output logic             open_err,
    output logic             cnt_err
);
    typedef struct packed {
        logic        out;
        logic        held;
        logic [31:0] cnt;
        logic        open_err;
        logic        cnt_err;
    } vos_ch_s;

    vos_ch_s q, d;
    logic [1:0] act;

    always_comb begin
        d   = q;
        act = vos_pkg::ACT_OFF;
        if (!(comm_fault || comm_idle)) begin
            d.out  = cmd;
            d.held = cmd;
        end else begin
            // RL8 RL13 priority select
            if (prio_ht) begin
                // Fault beats idle: a broken link is the harder case
                act = comm_fault ? fault_act : idle_act;
            end else begin
                act = unit_hold ? vos_pkg::ACT_HOLD : vos_pkg::ACT_OFF;
            end
            // RL7 fault idle action
            unique case (act)
                vos_pkg::ACT_HOLD:     d.out = q.held;
                vos_pkg::ACT_FORCE_ON: d.out = 1'b1;
                default:               d.out = 1'b0;
            endcase
        end
        // RL9 RL11 count, restore
        if (load_valid) begin
            d.cnt = load_count;
        end else if (d.out && !q.out && q.cnt != 32'hffff_ffff) begin
            d.cnt = q.cnt + 32'h0000_0001;
        end
        // RL6 open circuit error
        d.open_err = open_en && open_sense;
        // RL9 RL10 limit scaled
        d.cnt_err = cnt_en && (q.cnt > 32'(limit) * vos_pkg::LIMIT_UNIT);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign valve_out = q.out;
    assign count     = q.cnt;
    assign open_err  = q.open_err;
    assign cnt_err   = q.cnt_err;
endmodule // vos_channel
`default_nettype wire

// ---- hdl/vos_top.sv ----
// Valve output supervision: monitors, fail-safe outputs, counters, registers
// Operation
// [RL1] Control supply monitor on by default; error above 26 V or below 21 V
// [RL2] Output supply monitor on by default; error above 26 V or below 20 V
// [RL3] Short detection on by default raises unit error; off raises none
// [RL4] Automatic restart, the default, clears short error once short is gone
// [RL5] Manual restart keeps short error latched until next power-up; clearing short enable clears it too
// [RL6] Open detection, off by default, raises error per disconnected channel
// [RL7] Per channel fault and idle actions: off default, hold or force on
// [RL8] Per channel actions apply only when priority selects the terminal
// [RL9] Count each activation; error above limit if counter error enabled
// [RL10] Limit accepted 1 to 65000, compared in thousands of activations
// [RL11] Save counts every 30 s; resume from saved value after power-up
// [RL12] Open enable, actions and counter settings writable by terminal only
// [RL13] Priority picks unit switch off/hold or terminal per channel actions
// [RL14] Both writers equal, latest wins; master values restored on relink (code gives the bus write priority in the same cycle)
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vos_top #(
    parameter int          NCH         = 8,
    parameter logic [31:0] SAVE_CYCLES = vos_pkg::SAVE_CYCLES,
    localparam int         CW          = (NCH > 1) ? $clog2(NCH) : 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             ht_wr_en,
    input  wire logic [7:0]       ht_addr,
    input  wire logic [31:0]      ht_wdata,
    input  wire logic             link_up,
    input  wire logic             comm_fault,
    input  wire logic             comm_idle,
    input  wire logic             unit_hold,
    input  wire logic [NCH-1:0]   valve_cmd,
    input  wire logic [15:0]      ctrl_supply_mv,
    input  wire logic [15:0]      out_supply_mv,
    input  wire logic             short_sense,
    input  wire logic [NCH-1:0]   open_sense,
    output logic [NCH-1:0]        valve_out,
    input  wire logic             nvm_load_valid,
    input  wire logic [CW-1:0]    nvm_load_ch,
    input  wire logic [31:0]      nvm_load_count,
    output logic                  nvm_save_valid,
    output logic [CW-1:0]         nvm_save_ch,
    output logic [31:0]           nvm_save_count,
    output logic                  irq
);
    typedef struct packed {
        logic                           ack;
        logic [31:0]                    rdata;
        logic [vos_pkg::CTRL_W-1:0]     ctrl;
        logic [vos_pkg::CTRL_W-1:0]     master_ctrl;
        logic                           open_en;
        logic                           cnt_en;
        logic [15:0]                    limit;
        logic [2*NCH-1:0]               fault_act;
        logic [2*NCH-1:0]               idle_act;
        logic                           ctrl_err;
        logic                           out_err;
        logic                           short_err;
        logic [vos_pkg::EV_W-1:0]       irq_stat;
        logic [vos_pkg::EV_W-1:0]       irq_mask;
        logic [CW-1:0]                  cnt_sel;
        logic                           link_prev;
        vos_pkg::vos_save_e             save_st;
        logic [31:0]                    save_tmr;
        logic [CW-1:0]                  save_idx;
        logic                           save_valid;
        logic [CW-1:0]                  save_ch;
        logic [31:0]                    save_cnt;
    } vos_top_s;

    vos_top_s q, d;

    logic [NCH-1:0]      ch_open_err;
    logic [NCH-1:0]      ch_cnt_err;
    logic [NCH*32-1:0]   ch_count;
    logic [vos_pkg::EV_W-1:0] unit_err;
    logic [vos_pkg::EV_W-1:0] ev_set;
    logic                wb_req;
    logic                wb_wr;
    logic                wb_rd;
    logic [31:0]         wb_wmask;
    logic [31:0]         rd_mux;
    logic                ctrl_bad;
    logic                out_bad;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            vos_channel u_ch (
                .clk        (clk),
                .rst        (rst),
                .cmd        (valve_cmd[g]),
                .comm_fault (comm_fault),
                .comm_idle  (comm_idle),
                // RL8 priority gates
                .prio_ht    (q.ctrl[vos_pkg::PRIO_HT_BIT]),
                .unit_hold  (unit_hold),
                .fault_act  (q.fault_act[2*g +: 2]),
                .idle_act   (q.idle_act[2*g +: 2]),
                .open_sense (open_sense[g]),
                .open_en    (q.open_en),
                .cnt_en     (q.cnt_en),
                .limit      (q.limit),
                // RL11 restore count
                .load_valid (nvm_load_valid && nvm_load_ch == CW'(g)),
                .load_count (nvm_load_count),
                .valve_out  (valve_out[g]),
                .count      (ch_count[32*g +: 32]),
                .open_err   (ch_open_err[g]),
                .cnt_err    (ch_cnt_err[g])
            );
        end
    endgenerate

    // Byte lanes of a write
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wb_wmask[8*b +: 8] = {8{wb_sel_i[b]}};
        end
    end

    assign wb_req = wb_cyc_i && wb_stb_i;
    // Write and read-clear happen on the edge that sees ack high
    assign wb_wr  = wb_req && q.ack && wb_we_i;
    assign wb_rd  = wb_req && q.ack && !wb_we_i;

    // RL1 RL2 window compare
    assign ctrl_bad = (ctrl_supply_mv > vos_pkg::CTRL_HI_MV)
                   || (ctrl_supply_mv < vos_pkg::CTRL_LO_MV);
    assign out_bad  = (out_supply_mv > vos_pkg::OUT_HI_MV)
                   || (out_supply_mv < vos_pkg::OUT_LO_MV);

    always_comb begin
        unit_err = '0;
        unit_err[vos_pkg::EV_CTRL_SUP] = q.ctrl_err;
        unit_err[vos_pkg::EV_OUT_SUP]  = q.out_err;
        unit_err[vos_pkg::EV_SHORT]    = q.short_err;
        unit_err[vos_pkg::EV_OPEN]     = |ch_open_err;
        unit_err[vos_pkg::EV_COUNT]    = |ch_cnt_err;
        ev_set = unit_err;
    end

    always_comb begin
        rd_mux = '0;
        unique case (wb_adr_i)
            vos_pkg::OFF_CTRL:     rd_mux = 32'(q.ctrl);
            vos_pkg::OFF_HT_CFG:   rd_mux = 32'({q.cnt_en, q.open_en});
            vos_pkg::OFF_FAULT:    rd_mux = 32'(q.fault_act);
            vos_pkg::OFF_IDLE:     rd_mux = 32'(q.idle_act);
            vos_pkg::OFF_LIMIT:    rd_mux = 32'(q.limit);
            vos_pkg::OFF_UNIT_ERR: rd_mux = 32'(unit_err);
            vos_pkg::OFF_CH_ERR:   rd_mux = {16'h0000,
                                             8'(ch_cnt_err), 8'(ch_open_err)};
            vos_pkg::OFF_IRQ_STAT: rd_mux = 32'(q.irq_stat);
            vos_pkg::OFF_IRQ_MASK: rd_mux = 32'(q.irq_mask);
            vos_pkg::OFF_CNT_SEL:  rd_mux = 32'(q.cnt_sel);
            vos_pkg::OFF_CNT_VAL:  rd_mux = ch_count[32*q.cnt_sel +: 32];
            default:               rd_mux = '0;
        endcase
    end

    always_comb begin
        d = q;
        // Bus answer: one cycle after request, dropped the next cycle
        d.ack = wb_req && !q.ack;
        if (wb_req && !q.ack) begin
            d.rdata = rd_mux;
        end

        // RL14 latest writer wins; a bus write beats a terminal write in the same cycle
        if (wb_wr && wb_adr_i == vos_pkg::OFF_CTRL) begin
            d.ctrl = (q.ctrl & ~wb_wmask[vos_pkg::CTRL_W-1:0])
                   | (wb_dat_i[vos_pkg::CTRL_W-1:0]
                      & wb_wmask[vos_pkg::CTRL_W-1:0]);
            d.master_ctrl = d.ctrl;
        end else if (ht_wr_en && ht_addr == vos_pkg::OFF_CTRL) begin
            // Terminal writes leave the master copy untouched
            d.ctrl = ht_wdata[vos_pkg::CTRL_W-1:0];
        end
        // RL14 relink restores master
        d.link_prev = link_up;
        if (link_up && !q.link_prev) begin
            d.ctrl = q.master_ctrl;
        end

        // RL12 terminal only settings
        if (ht_wr_en) begin
            unique case (ht_addr)
                vos_pkg::OFF_HT_CFG: begin
                    d.open_en = ht_wdata[vos_pkg::OPEN_EN_BIT];
                    d.cnt_en  = ht_wdata[vos_pkg::CNT_EN_BIT];
                end
                vos_pkg::OFF_FAULT: d.fault_act = ht_wdata[2*NCH-1:0];
                vos_pkg::OFF_IDLE:  d.idle_act  = ht_wdata[2*NCH-1:0];
                vos_pkg::OFF_LIMIT: begin
                    // RL10 range check; out of range limit values dropped, enable bit still taken
                    if (ht_wdata[15:0] >= vos_pkg::LIMIT_MIN
                        && ht_wdata[15:0] <= vos_pkg::LIMIT_MAX) begin
                        d.limit = ht_wdata[15:0];
                    end
                    d.cnt_en = ht_wdata[vos_pkg::LIMIT_EN_BIT];
                end
                default: ;
            endcase
        end

        if (wb_wr && wb_adr_i == vos_pkg::OFF_IRQ_MASK) begin
            d.irq_mask = (q.irq_mask & ~wb_wmask[vos_pkg::EV_W-1:0])
                       | (wb_dat_i[vos_pkg::EV_W-1:0]
                          & wb_wmask[vos_pkg::EV_W-1:0]);
        end
        if (wb_wr && wb_adr_i == vos_pkg::OFF_CNT_SEL && wb_sel_i[0]) begin
            d.cnt_sel = wb_dat_i[CW-1:0];
        end

        // RL1 control supply window
        d.ctrl_err = q.ctrl[vos_pkg::CTRL_MON_BIT] && ctrl_bad;
        // RL2 output supply window
        d.out_err = q.ctrl[vos_pkg::OUT_MON_BIT] && out_bad;

        // RL3 short detect gate
        if (!q.ctrl[vos_pkg::SHORT_EN_BIT]) begin
            d.short_err = 1'b0;
        end else if (short_sense) begin
            d.short_err = 1'b1;
        end else if (!q.ctrl[vos_pkg::RESTART_MAN_BIT]) begin
            // RL4 auto restart clears
            d.short_err = 1'b0;
        end
        // RL5 manual latch: only reset, the power-up, clearing short enable, or auto restart with the short gone clears it

        // Read clears only bits it returned; a set still wins
        if (wb_rd && wb_adr_i == vos_pkg::OFF_IRQ_STAT) begin
            d.irq_stat = (q.irq_stat & ~q.rdata[vos_pkg::EV_W-1:0]) | ev_set;
        end else begin
            d.irq_stat = q.irq_stat | ev_set;
        end

        // RL11 periodic count save
        d.save_valid = 1'b0;
        unique case (q.save_st)
            vos_pkg::SV_WAIT: begin
                if (q.save_tmr >= SAVE_CYCLES - 32'h0000_0001) begin
                    d.save_tmr = '0;
                    d.save_idx = '0;
                    d.save_st  = vos_pkg::SV_SEND;
                end else begin
                    d.save_tmr = q.save_tmr + 32'h0000_0001;
                end
            end
            vos_pkg::SV_SEND: begin
                // One channel per cycle; the timer keeps running meanwhile
                d.save_tmr   = q.save_tmr + 32'h0000_0001;
                d.save_valid = 1'b1;
                d.save_ch    = q.save_idx;
                d.save_cnt   = ch_count[32*q.save_idx +: 32];
                if (q.save_idx == CW'(NCH - 1)) begin
                    d.save_st = vos_pkg::SV_WAIT;
                end else begin
                    d.save_idx = q.save_idx + CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q             <= '0;
            q.ctrl        <= vos_pkg::CTRL_RST;
            q.master_ctrl <= vos_pkg::CTRL_RST;
            q.limit       <= vos_pkg::LIMIT_RST;
            q.save_st     <= vos_pkg::SV_WAIT;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o       = q.ack;
    assign wb_dat_o       = q.rdata;
    assign nvm_save_valid = q.save_valid;
    assign nvm_save_ch    = q.save_ch;
    assign nvm_save_count = q.save_cnt;
    assign irq            = |(q.irq_stat & q.irq_mask);
endmodule // vos_top
`default_nettype wire

// ---- verif/vos_top_sva.sv ----
// Concurrent checks on the valve output supervision top ports
`timescale 1ns/1ps
`default_nettype none
module vos_top_sva #(
    parameter int          NCH         = 8,
    parameter logic [31:0] SAVE_CYCLES = 32'h32,
    localparam int         CW          = (NCH > 1) ? $clog2(NCH) : 1
) (
    input wire logic           clk,
    input wire logic           rst,
    input wire logic           wb_cyc_i,
    input wire logic           wb_stb_i,
    input wire logic           wb_we_i,
    input wire logic           wb_ack_o,
    input wire logic           comm_fault,
    input wire logic           comm_idle,
    input wire logic [NCH-1:0] valve_cmd,
    input wire logic [NCH-1:0] valve_out,
    input wire logic           nvm_save_valid,
    input wire logic [CW-1:0]  nvm_save_ch,
    input wire logic           irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Cycles since the last save burst began
    logic [31:0] gap_q;
    logic        seen_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else if ($rose(nvm_save_valid)) begin
            gap_q  <= 32'h1;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end

    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !wb_ack_o && !irq && valve_out == '0 && !nvm_save_valid)
        else $error("outputs active after reset");
    a_valve_follow: assert property (
        !comm_fault && !comm_idle |=> valve_out == $past(valve_cmd))
        else $error("valve output not following command");
    a_save_first: assert property (
        $rose(nvm_save_valid) |-> nvm_save_ch == '0)
        else $error("save burst not starting at channel zero");
    a_save_step: assert property (
        nvm_save_valid && nvm_save_ch != CW'(NCH - 1) |=>
        nvm_save_valid && nvm_save_ch == $past(nvm_save_ch) + 1'b1)
        else $error("save burst channel order broken");
    a_save_end: assert property (
        nvm_save_valid && nvm_save_ch == CW'(NCH - 1) |=> !nvm_save_valid)
        else $error("save burst too long");
    a_save_period: assert property (
        $rose(nvm_save_valid) && seen_q |-> gap_q == SAVE_CYCLES)
        else $error("save period wrong");

    c_write: cover property (wb_ack_o && wb_we_i);
    c_irq: cover property ($rose(irq));
    c_save: cover property ($rose(nvm_save_valid) && seen_q);
endmodule // vos_top_sva

bind vos_top vos_top_sva #(.NCH(NCH), .SAVE_CYCLES(SAVE_CYCLES)) u_sva (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .comm_fault,
    .comm_idle, .valve_cmd, .valve_out, .nvm_save_valid, .nvm_save_ch, .irq
);
`default_nettype wire

// ---- verif/vos_nvm_model.sv ----
// Persistent count store behind the save and load ports
`timescale 1ns/1ps
`default_nettype none
module vos_nvm_model #(
    parameter int NCH = 8,
    parameter int CW  = 3
) (
    input  wire logic          clk,
    input  wire logic          save_valid,
    input  wire logic [CW-1:0] save_ch,
    input  wire logic [31:0]   save_count,
    input  wire logic          replay,
    output logic               load_valid,
    output logic [CW-1:0]      load_ch,
    output logic [31:0]        load_count
);
    logic [31:0] mem [NCH];
    int          idx = NCH;

    initial begin
        load_valid = 1'b0;
        load_ch    = '0;
        load_count = 32'h0;
    end

    always @(posedge clk) begin
        if (save_valid)
            mem[save_ch] <= save_count;
        if (replay)
            idx <= 0;
        else if (idx < NCH)
            idx <= idx + 1;
        // replay when the replay input pulses; idle data toggles so it is never reused
        load_valid <= (idx < NCH);
        load_ch    <= CW'(idx);
        load_count <= (idx < NCH) ? mem[idx] : ~load_count;
    end
endmodule // vos_nvm_model
`default_nettype wire

// ---- verif/vos_top_test.sv ----
// Self-checking bench for the valve output supervision block
`timescale 1ns/1ps
`default_nettype none
module vos_top_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ht_wr_en = 1'b0;
    logic [7:0]  ht_addr = 8'h00;
    logic [31:0] ht_wdata = 32'h0;
    logic        link_up = 1'b1;
    logic        comm_fault = 1'b0;
    logic        comm_idle = 1'b0;
    logic        unit_hold = 1'b0;
    logic [7:0]  valve_cmd = 8'h00;
    logic [15:0] ctrl_supply_mv = 16'h5dc0;
    logic [15:0] out_supply_mv = 16'h5dc0;
    logic        short_sense = 1'b0;
    logic [7:0]  open_sense = 8'h00;
    logic [7:0]  valve_out;
    logic        nvm_load_valid;
    logic [2:0]  nvm_load_ch;
    logic [31:0] nvm_load_count;
    logic        nvm_save_valid;
    logic [2:0]  nvm_save_ch;
    logic [31:0] nvm_save_count;
    logic        irq;
    logic        replay = 1'b0;
    logic [31:0] q;
    int          failures = 0;
    int          checks_done = 0;
    // Control mv, output mv, expected unit error; edges of both windows
    logic [47:0] sup [7] = '{48'h6591_5dc0_0001, 48'h5207_5dc0_0001,
        48'h5208_6590_0000, 48'h5dc0_4e1f_0002, 48'h5dc0_6591_0002,
        48'h5dc0_4e20_0000, 48'h5dc0_5dc0_0000};

    // Short save period keeps the persistence test brief
    vos_top #(.NCH(8), .SAVE_CYCLES(32'h32)) uut (
        .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .ht_wr_en, .ht_addr, .ht_wdata,
        .link_up, .comm_fault, .comm_idle, .unit_hold, .valve_cmd,
        .ctrl_supply_mv, .out_supply_mv, .short_sense, .open_sense,
        .valve_out, .nvm_load_valid, .nvm_load_ch, .nvm_load_count,
        .nvm_save_valid, .nvm_save_ch, .nvm_save_count, .irq
    );
    vos_nvm_model #(.NCH(8), .CW(3)) nvm (
        .clk, .save_valid(nvm_save_valid), .save_ch(nvm_save_ch),
        .save_count(nvm_save_count), .replay, .load_valid(nvm_load_valid),
        .load_ch(nvm_load_ch), .load_count(nvm_load_count)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic ht(input logic [7:0] a, input logic [31:0] d);
        ht_wr_en <= 1'b1;
        ht_addr  <= a;
        ht_wdata <= d;
        @(posedge clk);
        ht_wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Leaves about 40 cycles before the next periodic save
    task automatic wait_save;
        @(posedge clk iff nvm_save_valid);
        cyc_n(10);
    endtask

    task automatic restore;
        replay <= 1'b1;
        @(posedge clk);
        replay <= 1'b0;
        cyc_n(12);
    endtask

    task automatic wrap_up;
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        cyc_n(20000);
        failures++;
        wrap_up();
    end

    initial begin
        cyc_n(8);
        rst <= 1'b0;
        rd(8'h00, 32'h07);
        rd(8'h10, 32'hfde8);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h3);
        rd(8'h04, 32'h0);
        wr(8'h3c, 32'h5);
        rd(8'h3c, 32'h0);
        for (int i = 0; i < 7; i++) begin
            ctrl_supply_mv <= sup[i][47:32];
            out_supply_mv  <= sup[i][31:16];
            cyc_n(3);
            rd(8'h14, {16'h0, sup[i][15:0]});
        end
        wr(8'h00, 32'h04);
        ctrl_supply_mv <= 16'h6591;
        out_supply_mv  <= 16'h4e1f;
        cyc_n(3);
        rd(8'h14, 32'h0);
        ctrl_supply_mv <= 16'h5dc0;
        out_supply_mv  <= 16'h5dc0;
        wr(8'h00, 32'h07);
        wb(1'b0, 8'h1c, 32'h0);
        short_sense <= 1'b1;
        cyc_n(3);
        rd(8'h14, 32'h04);
        short_sense <= 1'b0;
        cyc_n(3);
        rd(8'h14, 32'h0);
        chk(32'(irq), 32'h0);
        wr(8'h20, 32'h04);
        chk(32'(irq), 32'h1);
        rd(8'h1c, 32'h04);
        chk(32'(irq), 32'h0);
        wr(8'h00, 32'h0f);
        short_sense <= 1'b1;
        cyc_n(3);
        short_sense <= 1'b0;
        cyc_n(3);
        rd(8'h14, 32'h04);
        wr(8'h00, 32'h0b);
        short_sense <= 1'b1;
        cyc_n(3);
        rd(8'h14, 32'h0);
        short_sense <= 1'b0;
        open_sense <= 8'h08;
        cyc_n(3);
        rd(8'h18, 32'h0);
        ht(8'h04, 32'h3);
        cyc_n(2);
        rd(8'h18, 32'h08);
        open_sense <= 8'h00;
        // Fault: ch1 hold, ch2 force on, ch3 code 11; idle: ch0 force on
        ht(8'h08, 32'he4);
        ht(8'h0c, 32'h2);
        valve_cmd <= 8'h03;
        cyc_n(3);
        unit_hold <= 1'b1;
        comm_fault <= 1'b1;
        cyc_n(3);
        chk(32'(valve_out), 32'h03);
        unit_hold <= 1'b0;
        cyc_n(3);
        chk(32'(valve_out), 32'h0);
        wr(8'h00, 32'h17);
        cyc_n(2);
        chk(32'(valve_out), 32'h06);
        comm_fault <= 1'b0;
        comm_idle <= 1'b1;
        cyc_n(3);
        chk(32'(valve_out), 32'h01);
        comm_idle <= 1'b0;
        valve_cmd <= 8'h00;
        ht(8'h00, 32'h07);
        rd(8'h00, 32'h07);
        link_up <= 1'b0;
        cyc_n(2);
        link_up <= 1'b1;
        cyc_n(3);
        rd(8'h00, 32'h17);
        ht(8'h10, 32'h10000);
        rd(8'h10, 32'hfde8);
        ht(8'h10, 32'h1fde9);
        rd(8'h10, 32'hfde8);
        ht(8'h10, 32'h10001);
        wait_save();
        nvm.mem[0] = 32'h3e8;
        restore();
        rd(8'h18, 32'h0);
        valve_cmd <= 8'h01;
        cyc_n(4);
        rd(8'h18, 32'h100);
        wr(8'h24, 32'h0);
        rd(8'h28, 32'h3e9);
        valve_cmd <= 8'h00;
        wait_save();
        chk(nvm.mem[0], 32'h3e9);
        rst <= 1'b1;
        cyc_n(2);
        rst <= 1'b0;
        rd(8'h28, 32'h0);
        restore();
        rd(8'h28, 32'h3e9);
        wrap_up();
    end
endmodule // vos_top_test
`default_nettype wire
